// ==== design/ddrlp_regs.svh ====
// constants for the ddr low-power and reset control block
`ifndef DDRLP_REGS_SVH
`define DDRLP_REGS_SVH
`define DDRLP_ADDR_W        4
`define DDRLP_OFS_REFCTL    4'h0
`define DDRLP_OFS_TIMING2   4'h1
`define DDRLP_OFS_CONFIG2   4'h2
`define DDRLP_OFS_CALCTL    4'h3
`define DDRLP_OFS_STATUS    4'h4
`define DDRLP_OFS_CONFIG    4'h5
`define DDRLP_REFCTL_REQ    31
`define DDRLP_REFCTL_SEL    30
`define DDRLP_REFCTL_RATE_W 16
`define DDRLP_CAL_START     0
`define DDRLP_CFG_MDDR      0
`define DDRLP_CFG_BANKPOS   1
`define DDRLP_REFCTL_RST    32'h0000_0100
`define DDRLP_TIMING2_RST   32'h0003_0303
`define DDRLP_MUST_LEVEL    4'hB
`define DDRLP_BACKLOG_MAX   4'hF
`define DDRLP_INIT_CYC      8'h10
`define DDRLP_CAL_CYC       8'h08
`endif

// ==== design/ddrlp_pkg.sv ====
// types for the ddr low-power and reset control block
package ddrlp_pkg;
   typedef enum logic [3:0] {
      DDRLP_INIT     = 4'h0,
      DDRLP_IDLE     = 4'h1,
      DDRLP_DRAIN    = 4'h2,
      DDRLP_SELFREF  = 4'h3,
      DDRLP_PDOWN    = 4'h4,
      DDRLP_EXIT_WT  = 4'h5,
      DDRLP_AREF     = 4'h6,
      DDRLP_SERVICE  = 4'h7
   } ddrlp_state_t;
   typedef enum logic [2:0] {
      DDRLP_CMD_NOP  = 3'h0,
      DDRLP_CMD_PRE  = 3'h1,
      DDRLP_CMD_REF  = 3'h2,
      DDRLP_CMD_SREF = 3'h3,
      DDRLP_CMD_PD   = 3'h4,
      DDRLP_CMD_EMRS = 3'h5
   } ddrlp_cmd_t;
   typedef struct packed {
      logic [7:0] cke_min;
      logic [7:0] exit_nonrw;
      logic [7:0] exit_rw;
      logic [7:0] pd_exit;
   } ddrlp_timing_t;
   typedef struct packed {
      logic       req;
      logic       sel;
      logic [15:0] rate;
   } ddrlp_refctl_t;
endpackage

// ==== design/ddrlp_refresh.sv ====
// refresh interval and backlog counters
`timescale 1ns/1ns
`default_nettype none
`include "ddrlp_regs.svh"
module ddrlp_refresh
   import ddrlp_pkg::*;
(
   // clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   // control
   input  wire logic        i_halt,
   input  wire logic [15:0] i_rate,
   input  wire logic        i_done,
   // status
   output logic [3:0]       o_backlog,
   output logic             o_must
);
   typedef struct packed {
      logic [15:0] cnt;
      logic [3:0]  backlog;
   } ddrlp_rf_t;
   ddrlp_rf_t s_r, s_nxt;
   always_comb begin
      s_nxt = s_r;
      if (!i_halt) begin                                           // R25
         if (s_r.cnt == 16'h0000) begin
            s_nxt.cnt = i_rate;
            if (s_r.backlog != `DDRLP_BACKLOG_MAX)
               s_nxt.backlog = s_r.backlog + 4'h1;
         end else begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
         end
      end
      if (i_done && s_nxt.backlog != 4'h0)
         s_nxt.backlog = s_nxt.backlog - 4'h1;
   end
   always_ff @(posedge i_core_clk) begin
      if (i_reset)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
   assign o_backlog = s_r.backlog;
   assign o_must    = s_r.backlog > `DDRLP_MUST_LEVEL;                 // R24
endmodule
`default_nettype wire

// ==== design/ddrlp_ctrl.sv ====
// low-power and reset control of a ddr2 / mobile ddr controller
//
// Summary of operation
// R1: select 0 then request 1 puts the SDRAM into self-refresh.
// R2: finish accesses and backlog, close rows, then issue self-refresh.
// R3: self-refresh exits on access, request cleared, or select set.
// R4: access during self-refresh is served, then self-refresh re-entered.
// R5: no self-refresh exit before cke_min_cycles plus one cycles.
// R6: DDR2 waits exit delays plus one before non-rw and rw commands.
// R7: mobile DDR waits nonrw delay plus one, then one auto-refresh.
// R8: system restores stable clocks before any self-refresh exit.
// R9: partial_refresh_sel codes 0,1,2,5,6 valid; 3,4,7 reserved.
// R10: partial_refresh_sel goes into the extended mode register at init; init issues the EMRS only when mddr is set.
// R11: bank interleave when bank_position_sel is 0.
// R12: select 1 and request 1 puts DDR2 into power-down.
// R13: before power-down finish work, close rows, NOP with CKE low.
// R14: power-down exits on access, Must level, request cleared, select 0.
// R15: access during power-down is served, then power-down re-entered.
// R16: no power-down exit before cke_min_cycles plus one cycles.
// R17: on power-down exit drive CKE high, wait pd_exit_delay plus one.
// R18: module reset clears registers and fsm; state reset only the fsm.
// R19: either reset release starts init and flushes queued work.
// R20: masters make no accesses while a reset is asserted.
// R21: state reset from power controller, module reset from device reset.
// R22: software runs impedance calibration before using the controller.
// R23: after state reset without calibration clock, accesses stall.
// R24: Refresh Must level reached when backlog exceeds 11.
// R25: refresh counters halt during self-refresh.
`timescale 1ns/1ns
`default_nettype none
`include "ddrlp_regs.svh"
module ddrlp_ctrl
   import ddrlp_pkg::*;
(
   // clock and resets
   input  wire logic                     i_core_clk,
   input  wire logic                     i_reset,
   input  wire logic                     i_module_reset_n,
   input  wire logic                     i_state_reset_n,
   // register port
   input  wire logic [`DDRLP_ADDR_W-1:0] i_reg_addr,
   input  wire logic [31:0]              i_reg_wdata,
   input  wire logic                     i_reg_wr,
   input  wire logic                     i_reg_rd,
   output logic [31:0]                   o_reg_rdata,
   // access side
   input  wire logic                     i_access_req,
   input  wire logic                     i_access_rw,
   input  wire logic                     i_access_done,
   input  wire logic                     i_cal_clk_on,
   output logic                          o_access_grant,
   output logic                          o_rw_allowed,
   output logic                          o_flush,
   // sdram side
   output logic                          o_cke,
   output logic [2:0]                    o_cmd,
   output logic [2:0]                    o_emrs_partial_refresh_sel,
   output logic                          o_bank_interleave
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      ddrlp_state_t  st;
      ddrlp_refctl_t refctl;
      ddrlp_timing_t tim;
      logic [2:0]    partial_refresh_sel;
      logic          mddr;
      logic          bankpos;
      logic          cal_ok;
      logic [7:0]    cal_cnt;
      logic [7:0]    cnt;
      logic [7:0]    rw_cnt;
      logic          lp_sr;
      logic [31:0]   rdata;
      logic          cke;
      logic [2:0]    cmd;
      logic          grant;
      logic          rw_ok;
      logic          flush;
   } ddrlp_s_t;
   ddrlp_s_t s_r, s_nxt;
   logic [3:0] backlog;
   logic       must;
   logic       ref_done;
   logic       rst_mod;
   logic       rst_fsm;
   ////////////////////////////////////////////////////////////////////////
   function automatic logic partial_refresh_sel_ok(input logic [2:0] c);
      partial_refresh_sel_ok = (c == 3'h0) || (c == 3'h1) || (c == 3'h2) ||
                (c == 3'h5) || (c == 3'h6);                            // R9
   endfunction
   function automatic logic [7:0] plus1(input logic [7:0] v);
      plus1 = v + 8'h01;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   assign rst_mod  = i_reset || !i_module_reset_n;                     // R18
   assign rst_fsm  = rst_mod || !i_state_reset_n;                      // R18
   assign ref_done = (s_r.cmd == DDRLP_CMD_REF);
   ddrlp_refresh u_refresh (
      .i_core_clk (i_core_clk),
      .i_reset    (rst_fsm),
      .i_halt     (s_r.st == DDRLP_SELFREF),                           // R25
      .i_rate     (s_r.refctl.rate),
      .i_done     (ref_done),
      .o_backlog  (backlog),
      .o_must     (must)
   );
   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic wake;
      logic lp_want;
      wake    = 1'b0;
      lp_want = s_r.refctl.req;
      s_nxt       = s_r;
      s_nxt.cmd   = DDRLP_CMD_NOP;
      s_nxt.grant = 1'b0;
      s_nxt.flush = 1'b0;
      s_nxt.rdata = 32'h0000_0000;
      // register writes
      if (i_reg_wr) begin
         unique case (i_reg_addr)
            `DDRLP_OFS_REFCTL: begin
               s_nxt.refctl.req  = i_reg_wdata[`DDRLP_REFCTL_REQ];
               s_nxt.refctl.sel  = i_reg_wdata[`DDRLP_REFCTL_SEL];
               s_nxt.refctl.rate = i_reg_wdata[`DDRLP_REFCTL_RATE_W-1:0];
            end
            `DDRLP_OFS_TIMING2: s_nxt.tim = i_reg_wdata;
            `DDRLP_OFS_CONFIG2: begin
               if (partial_refresh_sel_ok(i_reg_wdata[2:0]))                          // R9
                  s_nxt.partial_refresh_sel = i_reg_wdata[2:0];
            end
            `DDRLP_OFS_CALCTL: begin
               if (i_reg_wdata[`DDRLP_CAL_START] && i_cal_clk_on) begin
                  s_nxt.cal_cnt = `DDRLP_CAL_CYC;                      // R22
                  s_nxt.cal_ok  = 1'b0;
               end
            end
            `DDRLP_OFS_CONFIG: begin
               s_nxt.mddr    = i_reg_wdata[`DDRLP_CFG_MDDR];
               s_nxt.bankpos = i_reg_wdata[`DDRLP_CFG_BANKPOS];        // R11
            end
            default: ;
         endcase
      end
      // register reads
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            `DDRLP_OFS_REFCTL:
               s_nxt.rdata = {s_r.refctl.req, s_r.refctl.sel, 14'h0000,
                              s_r.refctl.rate};
            `DDRLP_OFS_TIMING2: s_nxt.rdata = s_r.tim;
            `DDRLP_OFS_CONFIG2: s_nxt.rdata = {29'h0, s_r.partial_refresh_sel};
            `DDRLP_OFS_CALCTL:  s_nxt.rdata = {31'h0, s_r.cal_ok};
            `DDRLP_OFS_STATUS:
               s_nxt.rdata = {20'h00000, backlog, 3'h0, s_r.cke,
                              s_r.st};
            `DDRLP_OFS_CONFIG:
               s_nxt.rdata = {30'h0, s_r.bankpos, s_r.mddr};
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // calibration timer
      if (s_r.cal_cnt != 8'h00) begin
         if (!i_cal_clk_on) begin
            s_nxt.cal_cnt = s_r.cal_cnt;                               // R23
         end else begin
            s_nxt.cal_cnt = s_r.cal_cnt - 8'h01;
            if (s_r.cal_cnt == 8'h01)
               s_nxt.cal_ok = 1'b1;
         end
      end
      if (s_r.cnt != 8'h00)
         s_nxt.cnt = s_r.cnt - 8'h01;
      if (s_r.rw_cnt != 8'h00)
         s_nxt.rw_cnt = s_r.rw_cnt - 8'h01;
      s_nxt.rw_ok = (s_nxt.rw_cnt == 8'h00) && (s_r.st == DDRLP_IDLE ||
                    s_r.st == DDRLP_SERVICE);                          // R6
      // state machine
      unique case (s_r.st)
         DDRLP_INIT: begin
            s_nxt.cke = 1'b1;
            if (s_r.cnt == 8'h02 && s_r.mddr)
               s_nxt.cmd = DDRLP_CMD_EMRS;                             // R10
            if (s_r.cnt == 8'h01)
               s_nxt.cmd = DDRLP_CMD_REF;
            if (s_r.cnt == 8'h00)
               s_nxt.st = DDRLP_IDLE;
         end
         DDRLP_IDLE: begin
            if (must) begin
               s_nxt.cmd = DDRLP_CMD_REF;
            end else if (i_access_req && s_r.cal_ok) begin             // R23
               s_nxt.grant = 1'b1;
               s_nxt.st    = DDRLP_SERVICE;
            end else if (lp_want) begin
               s_nxt.st = DDRLP_DRAIN;                                 // R2
            end
         end
         DDRLP_SERVICE: begin
            s_nxt.grant = 1'b0;
            if (i_access_done) begin
               s_nxt.st = lp_want ? DDRLP_DRAIN : DDRLP_IDLE;          // R4
            end
         end
         DDRLP_DRAIN: begin
            if (!lp_want) begin
               s_nxt.st = DDRLP_IDLE;
            end else if (i_access_req && s_r.cal_ok) begin
               s_nxt.grant = 1'b1;
               s_nxt.st    = DDRLP_SERVICE;                            // R2
            end else if (backlog != 4'h0) begin
               s_nxt.cmd = DDRLP_CMD_REF;                              // R2
            end else if (s_r.cmd == DDRLP_CMD_PRE) begin
               s_nxt.cnt   = plus1(s_r.tim.cke_min);
               s_nxt.lp_sr = !s_r.refctl.sel;
               s_nxt.cke   = 1'b0;
               if (!s_r.refctl.sel) begin
                  s_nxt.cmd = DDRLP_CMD_SREF;                          // R1
                  s_nxt.st  = DDRLP_SELFREF;
               end else begin
                  s_nxt.cmd = DDRLP_CMD_PD;                            // R13
                  s_nxt.st  = DDRLP_PDOWN;                             // R12
               end
            end else begin
               s_nxt.cmd = DDRLP_CMD_PRE;                              // R13
            end
         end
         DDRLP_SELFREF: begin
            wake = i_access_req || !s_r.refctl.req ||
                   s_r.refctl.sel;                                     // R3
            if (wake && s_r.cnt == 8'h00) begin                        // R5
               s_nxt.cke    = 1'b1;
               s_nxt.cnt    = plus1(s_r.tim.exit_nonrw);               // R6
               s_nxt.rw_cnt = s_r.mddr ? 8'h00
                                       : plus1(s_r.tim.exit_rw);       // R6
               s_nxt.st     = DDRLP_EXIT_WT;
            end
         end
         DDRLP_PDOWN: begin
            wake = i_access_req || must || !s_r.refctl.req ||
                   !s_r.refctl.sel;                                    // R14
            if (wake && s_r.cnt == 8'h00) begin                        // R16
               s_nxt.cke = 1'b1;                                       // R17
               s_nxt.cnt = plus1(s_r.tim.pd_exit);                     // R17
               s_nxt.st  = DDRLP_EXIT_WT;
            end
         end
         DDRLP_EXIT_WT: begin
            if (s_r.cnt == 8'h00) begin
               if (s_r.lp_sr && s_r.mddr) begin
                  s_nxt.cmd = DDRLP_CMD_REF;                           // R7
                  s_nxt.st  = DDRLP_AREF;
               end else begin
                  s_nxt.st = DDRLP_IDLE;                               // R15
               end
            end
         end
         DDRLP_AREF: begin
            s_nxt.st = DDRLP_IDLE;                                     // R7
         end
         default: s_nxt.st = DDRLP_INIT;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_core_clk) begin
      if (rst_mod) begin
         s_r            <= '0;
         s_r.refctl     <= 18'(`DDRLP_REFCTL_RST);
         s_r.tim        <= `DDRLP_TIMING2_RST;
         s_r.st         <= DDRLP_INIT;
         s_r.cnt        <= `DDRLP_INIT_CYC;
         s_r.flush      <= 1'b1;
      end else if (rst_fsm) begin                                      // R18
         s_r.st         <= DDRLP_INIT;                                 // R19
         s_r.cnt        <= `DDRLP_INIT_CYC;
         s_r.rw_cnt     <= 8'h00;
         s_r.cke        <= 1'b0;
         s_r.cmd        <= DDRLP_CMD_NOP;
         s_r.grant      <= 1'b0;
         s_r.rw_ok      <= 1'b0;
         s_r.flush      <= 1'b1;                                       // R19
         s_r.rdata      <= 32'h0000_0000;
         s_r.cal_ok     <= s_r.cal_ok && i_cal_clk_on;                 // R23
         s_r.cal_cnt    <= 8'h00;
      end else begin
         s_r <= s_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   assign o_reg_rdata       = s_r.rdata;
   assign o_access_grant    = s_r.grant;
   assign o_rw_allowed      = s_r.rw_ok;
   assign o_flush           = s_r.flush;
   assign o_cke             = s_r.cke;
   assign o_cmd             = s_r.cmd;
   assign o_emrs_partial_refresh_sel       = s_r.partial_refresh_sel;                                // R10
   assign o_bank_interleave = !s_r.bankpos;                            // R11
endmodule
`default_nettype wire

// ==== tb/ddrlp_sdram_model.sv ====
// behavioural model of the attached ddr2 / mobile ddr sdram
`timescale 1ns/1ns
`default_nettype none
module ddrlp_sdram_model
   import ddrlp_pkg::*;
(
   // clock
   input  wire logic       i_core_clk,
   // command pins
   input  wire logic       i_cke,
   input  wire logic [2:0] i_cmd,
   input  wire logic [2:0] i_partial_refresh_sel,
   // observed device state
   output logic            o_sref = 1'b0,
   output logic            o_pdown = 1'b0,
   output logic [2:0]      o_partial_refresh_sel = 3'h0,
   output logic [7:0]      o_refs = 8'h00
);
   ////////////////////////////////////////////////////////////////////
   always @(posedge i_core_clk) begin
      if (i_cmd == DDRLP_CMD_SREF && !i_cke) o_sref <= 1'b1;
      if (i_cmd == DDRLP_CMD_PD && !i_cke) o_pdown <= 1'b1;
      if (i_cke) begin
         o_sref <= 1'b0;
         o_pdown <= 1'b0;
      end
      if (i_cmd == DDRLP_CMD_EMRS) o_partial_refresh_sel <= i_partial_refresh_sel;
      if (i_cmd == DDRLP_CMD_REF) o_refs <= o_refs + 8'h01;
   end
endmodule
`default_nettype wire

// ==== tb/ddrlp_ctrl_assertions.sv ====
// assertion checker for the ddr low-power and reset control block
`timescale 1ns/1ns
`default_nettype none
`include "ddrlp_regs.svh"
module ddrlp_chk
   import ddrlp_pkg::*;
(
   // clock and resets
   input wire logic                     i_core_clk,
   input wire logic                     i_reset,
   input wire logic                     i_module_reset_n,
   input wire logic                     i_state_reset_n,
   // register port
   input wire logic [`DDRLP_ADDR_W-1:0] i_reg_addr,
   input wire logic [31:0]              i_reg_wdata,
   input wire logic                     i_reg_wr,
   // access side
   input wire logic                     i_access_req,
   input wire logic                     o_access_grant,
   input wire logic                     o_rw_allowed,
   input wire logic                     o_flush,
   // sdram side
   input wire logic                     o_cke,
   input wire logic [2:0]               o_cmd,
   input wire logic [2:0]               o_emrs_partial_refresh_sel
);
   wire logic any_rst = i_reset | ~i_module_reset_n | ~i_state_reset_n;
   wire logic lp_cmd = o_cmd == DDRLP_CMD_SREF || o_cmd == DDRLP_CMD_PD;
   ddrlp_timing_t tim_r;
   logic [8:0]    lo_r, hi_r;
   logic [7:0]    wt_r, rw_r;
   logic          req_r, sel_r, mddr_r, due_r;
   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_core_clk) begin
      if (i_reset || !i_module_reset_n) begin
         tim_r <= `DDRLP_TIMING2_RST;
         {req_r, sel_r, mddr_r} <= 3'h0;
      end else if (i_reg_wr && i_reg_addr == `DDRLP_OFS_TIMING2) begin
         tim_r <= i_reg_wdata;
      end else if (i_reg_wr && i_reg_addr == `DDRLP_OFS_REFCTL) begin
         req_r <= i_reg_wdata[`DDRLP_REFCTL_REQ];
         sel_r <= i_reg_wdata[`DDRLP_REFCTL_SEL];
      end else if (i_reg_wr && i_reg_addr == `DDRLP_OFS_CONFIG) begin
         mddr_r <= i_reg_wdata[`DDRLP_CFG_MDDR];
      end
      if (any_rst) begin
         {lo_r, hi_r} <= {9'h1FF, 9'h1FF};
         {wt_r, rw_r, due_r} <= 17'h0;
      end else begin
         lo_r <= o_cke ? 9'h000 : lo_r + {8'h00, lo_r != 9'h1FF};
         hi_r <= !o_cke ? 9'h000 : hi_r + {8'h00, hi_r != 9'h1FF};
         if (o_cmd == DDRLP_CMD_SREF) begin
            wt_r <= tim_r.exit_nonrw;
            rw_r <= mddr_r ? tim_r.exit_nonrw : tim_r.exit_rw;
            due_r <= mddr_r;
         end else if (o_cmd == DDRLP_CMD_PD) begin
            {wt_r, rw_r} <= {tim_r.pd_exit, tim_r.pd_exit};
         end else if (o_cke && o_cmd != DDRLP_CMD_NOP) begin
            due_r <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (any_rst);
   sequence s_close;
      o_cmd == DDRLP_CMD_PRE ##1 lp_cmd;
   endsequence
   chk_close_rows: assert property (lp_cmd |-> $past(o_cmd) == 3'h1)
      else $error("low-power entry without precharge");
   chk_cke_low: assert property (s_close |-> !o_cke ##1 !o_cke)
      else $error("cke not low on low-power entry");
   chk_sref_cause: assert property (o_cmd == 3'h3 |-> req_r && !sel_r)
      else $error("self-refresh without its request");
   chk_pd_cause: assert property (o_cmd == 3'h4 |-> req_r && sel_r)
      else $error("power-down without its request");
   chk_cke_hold: assert property ($rose(o_cke) |-> lo_r > tim_r.cke_min)
      else $error("low-power exit too early");
   chk_exit_wait: assert property (o_cke && o_cmd != 3'h0 |-> hi_r > wt_r)
      else $error("command too soon after exit");
   chk_rw_wait: assert property (o_rw_allowed |-> o_cke && hi_r > rw_r)
      else $error("read or write allowed too soon");
   chk_mddr_ref: assert property (due_r && o_cke && o_cmd != 3'h0 |-> o_cmd == 3'h2)
      else $error("first mobile command not refresh");
   chk_quiet_low: assert property (!o_cke |-> o_cmd inside {3'h0, 3'h3, 3'h4})
      else $error("command while cke low");
   chk_partial_refresh_sel_code: assert property (o_emrs_partial_refresh_sel inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6})
      else $error("reserved refresh extent code");
   chk_grant_req: assert property (o_access_grant |-> $past(i_access_req) ##1 !o_access_grant)
      else $error("grant without request");
   chk_flush_rst: assert property (@(posedge i_core_clk) disable iff (i_reset)
      !(i_module_reset_n && i_state_reset_n) |=> o_flush)
      else $error("no flush during reset");
endmodule
bind ddrlp_ctrl ddrlp_chk i_ddrlp_chk (.i_core_clk, .i_reset,
   .i_module_reset_n, .i_state_reset_n, .i_reg_addr, .i_reg_wdata,
   .i_reg_wr, .i_access_req, .o_access_grant, .o_rw_allowed, .o_flush,
   .o_cke, .o_cmd, .o_emrs_partial_refresh_sel);
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the ddr low-power and reset control block
`timescale 1ns/1ns
`default_nettype none
`include "ddrlp_regs.svh"
module testbench
   import ddrlp_pkg::*;
;
   localparam logic [3:0] a_ref = `DDRLP_OFS_REFCTL;
   localparam logic [3:0] a_cal = `DDRLP_OFS_CALCTL;
   localparam logic [3:0] a_cf2 = `DDRLP_OFS_CONFIG2;
   logic        clk, rst, mrst_n, srst_n, wr, rd, areq, arw, adone, calon;
   logic        grant, rwok, flush, cke, bank, m_sref, m_pd, pend;
   logic [3:0]  addr;
   logic [2:0]  cmd, partial_refresh_sel, m_partial_refresh_sel;
   logic [7:0]  m_refs;
   logic [15:0] rt;
   logic [31:0] wdata, tm, r, rdata, pv;
   logic [31:0] exp_q[$];
   integer      seed = 32'h8eb3;
   int          err_count = 0, checked = 0, grants = 0, i;
   ////////////////////////////////////////////////////////////////////
   ddrlp_ctrl i_ddrlp_ctrl (.i_core_clk(clk), .i_reset(rst),
      .i_module_reset_n(mrst_n), .i_state_reset_n(srst_n),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
      .o_reg_rdata(rdata), .i_access_req(areq), .i_access_rw(arw),
      .i_access_done(adone), .i_cal_clk_on(calon), .o_access_grant(grant),
      .o_rw_allowed(rwok), .o_flush(flush), .o_cke(cke), .o_cmd(cmd),
      .o_emrs_partial_refresh_sel(partial_refresh_sel), .o_bank_interleave(bank));
   ddrlp_sdram_model i_ddrlp_sdram_model (.i_core_clk(clk), .i_cke(cke),
      .i_cmd(cmd), .i_partial_refresh_sel(partial_refresh_sel), .o_sref(m_sref), .o_pdown(m_pd),
      .o_partial_refresh_sel(m_partial_refresh_sel), .o_refs(m_refs));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (pend) check_val(rdata, exp_q.pop_front());
      pend <= rd;
      if (grant === 1'b1) grants++;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic check_val(input logic [31:0] got, input logic [31:0] e);
      checked++;
      if (got !== e) begin
         err_count++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, e);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic set_lp(input logic [1:0] m, input logic [15:0] rate);
      wr_reg(a_ref, {m, 14'h0, rate});
   endtask
   task automatic wait_cmd(input logic [2:0] c);
      int n;
      for (n = 0; n < 3000 && cmd !== c; n++) @(posedge clk);
      check_val({29'h0, cmd}, {29'h0, c});
   endtask
   task automatic access();
      int n;
      areq <= 1'b1;
      for (n = 0; n < 400 && grant !== 1'b1; n++) @(posedge clk);
      check_val({31'h0, grant}, 32'h1);
      areq <= 1'b0;
      adone <= 1'b1;
      @(posedge clk);
      adone <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      {rst, mrst_n, srst_n, wr, rd, areq, adone, calon} = 8'hA1;
      {addr, wdata, pend} = 37'h0;
      r = $random(seed);
      arw = r[0];
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      mrst_n <= 1'b1;
      rd_reg(a_ref, `DDRLP_REFCTL_RST);
      rd_reg(`DDRLP_OFS_TIMING2, `DDRLP_TIMING2_RST);
      rd_reg(4'hF, 32'h0);
      wr_reg(a_cal, 32'h1);
      repeat (`DDRLP_CAL_CYC + 2) @(posedge clk);
      rd_reg(a_cal, 32'h1);
      r = $random(seed);
      tm = 32'h0101_0101 + (r & 32'h0303_0303);
      rt = {8'h08, r[31:24]};
      wr_reg(`DDRLP_OFS_TIMING2, tm);
      wr_reg(`DDRLP_OFS_CONFIG, 32'h2);
      for (i = 0; i < 8; i++) begin
         if (i inside {0, 1, 2, 5, 6}) pv = 32'(i);
         wr_reg(a_cf2, 32'(i));
         rd_reg(a_cf2, pv);
      end
      check_val({31'h0, bank}, 32'h0);
      $display("done: registers");
      set_lp(2'b10, rt);
      wait_cmd(DDRLP_CMD_SREF);
      set_lp(2'b00, rt);
      repeat (30) @(posedge clk);
      check_val({30'h0, m_sref, rwok}, 32'h1);
      set_lp(2'b10, rt);
      wait_cmd(DDRLP_CMD_SREF);
      set_lp(2'b10, 16'h0010);
      repeat (250) @(posedge clk);
      rd_reg(`DDRLP_OFS_STATUS, 32'h3);
      set_lp(2'b10, rt);
      access();
      wait_cmd(DDRLP_CMD_SREF);
      set_lp(2'b11, rt);
      wait_cmd(DDRLP_CMD_PD);
      @(posedge clk);
      check_val({31'h0, m_pd}, 32'h1);
      access();
      wait_cmd(DDRLP_CMD_PD);
      set_lp(2'b11, 16'h0010);
      wait_cmd(DDRLP_CMD_REF);
      set_lp(2'b10, rt);
      wait_cmd(DDRLP_CMD_SREF);
      set_lp(2'b00, rt);
      $display("done: low power");
      wr_reg(`DDRLP_OFS_CONFIG, 32'h1);
      wr_reg(a_cf2, 32'h5);
      srst_n <= 1'b0;
      repeat (2) @(posedge clk);
      check_val({30'h0, flush, bank}, 32'h3);
      srst_n <= 1'b1;
      wait_cmd(DDRLP_CMD_EMRS);
      repeat (20) @(posedge clk);
      check_val({29'h0, m_partial_refresh_sel}, 32'h5);
      rd_reg(a_ref, {16'h0, rt});
      set_lp(2'b10, rt);
      wait_cmd(DDRLP_CMD_SREF);
      set_lp(2'b00, rt);
      wait_cmd(DDRLP_CMD_REF);
      $display("done: mobile and state reset");
      calon <= 1'b0;
      srst_n <= 1'b0;
      repeat (2) @(posedge clk);
      srst_n <= 1'b1;
      repeat (30) @(posedge clk);
      i = grants;
      areq <= 1'b1;
      repeat (40) @(posedge clk);
      check_val(32'(grants - i), 32'h0);
      areq <= 1'b0;
      calon <= 1'b1;
      wr_reg(a_cal, 32'h1);
      repeat (`DDRLP_CAL_CYC + 2) @(posedge clk);
      access();
      mrst_n <= 1'b0;
      repeat (2) @(posedge clk);
      mrst_n <= 1'b1;
      rd_reg(a_ref, `DDRLP_REFCTL_RST);
      repeat (4) @(posedge clk);
      $display("done: calibration and module reset");
      wrap_up();
   end
   initial begin
      repeat (30000) @(posedge clk);
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
   end
endmodule
`default_nettype wire
